//--- design/acs_pkg.sv
// Constants and types shared by the converter control block
`default_nettype none
package acs_pkg;
   // Clock
   localparam int CLK_MHZ = 50;
   // Converter word layout
   localparam int CODE_W = 14;
   localparam int SEL_W = 3;
   localparam int WORD_W = CODE_W + 2 * SEL_W;
   localparam int FIFO_DEPTH = 32;
   localparam logic [4:0] WORD_BITS = 5'd20;
   // Internal oscillator conversion time
   localparam int CONV_TIME_NS = 1000;
   localparam int CONV_CYCLES_INT = (CONV_TIME_NS * CLK_MHZ + 999) / 1000;
   localparam logic [15:0] CONV_CYCLES = CONV_CYCLES_INT[15:0];
   // Register offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_CONV = 8'h04;
   localparam logic [7:0] OFF_STATUS = 8'h08;
   localparam logic [7:0] OFF_LAST = 8'h0c;
   // Field positions
   localparam int CTRL_EN_BIT = 0;
   localparam int ST_BUSY_BIT = 0;
   localparam int ST_PD_N_BIT = 1;
   localparam int ST_SCAN_BIT = 2;
   localparam int ST_BYP_BIT = 3;
   localparam int ST_CHAN_LSB = 4;
   localparam int ST_GAIN_LSB = 8;
   localparam int ST_CNT_LSB = 16;
   // Reset values
   localparam logic CTRL_EN_RST = 1'b1;
   localparam logic [15:0] CONV_RST = CONV_CYCLES;
   // Pin synchroniser layout
   localparam int PIN_W = 12;
   localparam int P_PD = 0;
   localparam int P_CS = 1;
   localparam int P_SCK = 2;
   localparam int P_SCAN = 3;
   localparam int P_LPM = 4;
   localparam int P_BYP = 5;
   localparam int P_CHAN = 6;
   localparam int P_GAIN = 9;
   localparam int SYNC_STAGES = 2;

   typedef enum logic [1:0] {
      ST_IDLE,
      ST_CONV,
      ST_HOLD
   } acs_conv_e;
endpackage : acs_pkg
`default_nettype wire

//--- design/acs_ctrl.sv
// Converter control, scan sequencer, result FIFO and serial readout
//
// Functional notes
// - With start low and not busy, each shift clock rise sends next bit, MSB first.
// - Scan enable high lets the sequencer pick the channel, channel select pins ignored.
// - After scan enable rises, channel 0 first, then next on each start rise.
// - Falling edge of convert start ends sampling and starts a conversion.
// - Conversion timed by internal counter; converter powers down when done.
// - Convert start high turns the serial output driver off.
// - Convert start low with power-down high enables the serial output driver.
// - Reduced power: acquisition follows start high; converter off between conversions.
// - Gain select inputs are captured on the rising edge of convert start.
// - Channel select inputs are captured on the rising edge of convert start.
// - Floating gain msb line bypasses the amplifier for faster throughput.
// - Busy is high during a conversion and low once it completes.
// - Serial word is 14 code bits, then channel bits, then gain bits.
// - Power-down halts any conversion and puts the serial output off.
`default_nettype none

module acs_fifo #(
   parameter int WIDTH = 20,
   parameter int DEPTH = 32
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_clear,
   input wire logic i_in_valid,
   output logic o_in_ready,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_out_valid,
   input wire logic i_out_ready,
   output logic [WIDTH-1:0] o_out_data,
   output logic [$clog2(DEPTH):0] o_count
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   logic push;
   logic pop;

   assign o_count = wr_q - rd_q;
   assign o_in_ready = (o_count != DEPTH[AW:0]);
   assign o_out_valid = (wr_q != rd_q);
   assign o_out_data = mem[rd_q[AW-1:0]];
   assign push = i_in_valid && o_in_ready;
   assign pop = i_out_ready && o_out_valid;

   always_ff @(posedge i_clk) begin
      if (push) begin
         mem[wr_q[AW-1:0]] <= i_in_data;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst || i_clear) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule : acs_fifo

module acs_ctrl
   import acs_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   // APB slave
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   // Device pins
   input wire logic i_convert_start_n,
   input wire logic i_serial_shift_clock,
   input wire logic i_sequencer_enable,
   input wire logic i_reduced_power_config,
   input wire logic i_powerdown_n,
   input wire logic i_gain_sel_msb_float,
   input wire logic i_chan_sel_msb,
   input wire logic i_chan_sel_mid,
   input wire logic i_chan_sel_lsb,
   input wire logic i_gain_sel_msb_or_amp_bypass,
   input wire logic i_gain_sel_mid,
   input wire logic i_gain_sel_lsb,
   output logic o_busy,
   output logic o_serial_result_out,
   output logic o_serial_result_oe_n,
   // Analog core
   input wire logic [CODE_W-1:0] i_core_code,
   output logic o_core_power_on,
   output logic o_core_acquire,
   output logic [SEL_W-1:0] o_mux_chan,
   output logic [SEL_W-1:0] o_amp_gain,
   output logic o_amp_bypass
);
   logic [PIN_W-1:0] pin_raw;
   logic [PIN_W-1:0] s1_q;
   logic [PIN_W-1:0] s2_q;
   logic [PIN_W-1:0] s3_q;
   logic pd_n;
   logic cs_n;
   logic cs_fall;
   logic cs_rise;
   logic sck_rise;
   logic scan;
   logic scan_rise;
   logic reduced_power_config;
   logic ctrl_en_q;
   logic [15:0] conv_cyc_q;
   acs_conv_e state_q;
   logic [15:0] cnt_q;
   logic [SEL_W-1:0] chan_q;
   logic [SEL_W-1:0] gain_q;
   logic [SEL_W-1:0] seq_next_q;
   logic byp_q;
   logic [WORD_W-1:0] word_d;
   logic [WORD_W-1:0] last_q;
   logic push_valid;
   logic push_ready;
   logic pop_valid;
   logic pop_ready;
   logic [WORD_W-1:0] pop_data;
   logic [5:0] fifo_cnt;
   logic [WORD_W-1:0] shreg_q;
   logic [4:0] bits_q;
   logic wr_acc;
   logic setup;

   assign pin_raw = {i_gain_sel_msb_or_amp_bypass, i_gain_sel_mid, i_gain_sel_lsb,
                     i_chan_sel_msb, i_chan_sel_mid, i_chan_sel_lsb,
                     i_gain_sel_msb_float, i_reduced_power_config,
                     i_sequencer_enable, i_serial_shift_clock,
                     i_convert_start_n, i_powerdown_n};

   // Two-stage pin synchroniser, third stage for edge detection
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
      end else begin
         s1_q <= pin_raw[PIN_W-1:0];
         s2_q <= s1_q;
         s3_q <= s2_q;
      end
   end

   assign pd_n = s2_q[P_PD];
   assign cs_n = s2_q[P_CS];
   assign cs_fall = s3_q[P_CS] && !s2_q[P_CS];
   assign cs_rise = !s3_q[P_CS] && s2_q[P_CS];
   assign sck_rise = !s3_q[P_SCK] && s2_q[P_SCK];
   assign scan = s2_q[P_SCAN];
   assign scan_rise = !s3_q[P_SCAN] && s2_q[P_SCAN];
   assign reduced_power_config = s2_q[P_LPM];

   // Channel and gain capture, scan sequencer
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         chan_q <= '0;
         gain_q <= '0;
         seq_next_q <= '0;
         byp_q <= 1'b0;
      end else begin
         if (scan_rise) begin
            seq_next_q <= '0;
         end
         if (cs_rise) begin
            gain_q <= s2_q[P_GAIN +: SEL_W];
            byp_q <= s2_q[P_BYP];
            if (scan && !scan_rise) begin
               chan_q <= seq_next_q;
               seq_next_q <= seq_next_q + 1'b1;
            end else if (scan_rise) begin
               chan_q <= '0;
               seq_next_q <= 3'h1;
            end else begin
               chan_q <= s2_q[P_CHAN +: SEL_W];
            end
         end
      end
   end

   // Conversion sequencer
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
      end else if (!pd_n) begin
         state_q <= ST_IDLE;
         cnt_q <= '0;
      end else begin
         unique case (state_q)
            ST_IDLE: begin
               if (cs_fall && ctrl_en_q) begin
                  state_q <= ST_CONV;
                  cnt_q <= conv_cyc_q;
               end
            end
            ST_CONV: begin
               if (cnt_q <= 16'h0001) begin
                  state_q <= ST_HOLD;
               end else begin
                  cnt_q <= cnt_q - 1'b1;
               end
            end
            ST_HOLD: begin
               if (push_ready) begin
                  state_q <= ST_IDLE;
               end
            end
         endcase
      end
   end

   assign push_valid = (state_q == ST_HOLD);
   assign word_d = {i_core_code, chan_q, gain_q};

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         last_q <= '0;
      end else if (push_valid && push_ready) begin
         last_q <= word_d;
      end
   end

   // Busy, converter power and amplifier outputs
   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_busy <= 1'b0;
         o_core_power_on <= 1'b0;
         o_core_acquire <= 1'b0;
         o_mux_chan <= '0;
         o_amp_gain <= '0;
         o_amp_bypass <= 1'b0;
      end else begin
         o_busy <= pd_n && (state_q != ST_IDLE || (cs_fall && ctrl_en_q));
         o_core_power_on <= pd_n && (state_q == ST_CONV);
         o_core_acquire <= pd_n && (state_q == ST_IDLE) && (reduced_power_config ? cs_n : 1'b1);
         o_mux_chan <= chan_q;
         o_amp_gain <= gain_q;
         o_amp_bypass <= byp_q;
      end
   end

   acs_fifo #(
      .WIDTH(WORD_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_clear(!pd_n),
      .i_in_valid(push_valid),
      .o_in_ready(push_ready),
      .i_in_data(word_d),
      .o_out_valid(pop_valid),
      .i_out_ready(pop_ready),
      .o_out_data(pop_data),
      .o_count(fifo_cnt)
   );

   // Shifter takes a new word once the previous one is fully sent
   assign pop_ready = (bits_q == 5'd0) && pd_n;

   always_ff @(posedge i_clk) begin
      if (i_rst || !pd_n) begin
         shreg_q <= '0;
         bits_q <= '0;
         o_serial_result_out <= 1'b0;
      end else if (pop_ready && pop_valid) begin
         shreg_q <= pop_data;
         bits_q <= WORD_BITS;
      end else if (sck_rise && !cs_n && !o_busy && bits_q != 5'd0) begin
         o_serial_result_out <= shreg_q[WORD_W-1];
         shreg_q <= {shreg_q[WORD_W-2:0], 1'b0};
         bits_q <= bits_q - 1'b1;
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_serial_result_oe_n <= 1'b1;
      end else begin
         o_serial_result_oe_n <= cs_n || !pd_n;
      end
   end

   // APB slave, one wait-free access phase
   assign setup = i_psel && !i_penable;
   assign wr_acc = i_psel && i_penable && o_pready && i_pwrite;

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         ctrl_en_q <= CTRL_EN_RST;
         conv_cyc_q <= CONV_RST;
      end else if (wr_acc && !o_pslverr) begin
         if (i_paddr == OFF_CTRL) begin
            ctrl_en_q <= i_pwdata[CTRL_EN_BIT];
         end
         if (i_paddr == OFF_CONV) begin
            conv_cyc_q <= (i_pwdata[15:0] == 16'h0000) ? 16'h0001 : i_pwdata[15:0];
         end
      end
   end

   always_ff @(posedge i_clk) begin
      if (i_rst) begin
         o_pready <= 1'b0;
         o_pslverr <= 1'b0;
         o_prdata <= '0;
      end else begin
         o_pready <= setup;
         if (setup) begin
            o_pslverr <= 1'b0;
            o_prdata <= '0;
            unique case (i_paddr)
               OFF_CTRL: begin
                  o_prdata[CTRL_EN_BIT] <= ctrl_en_q;
               end
               OFF_CONV: begin
                  o_prdata[15:0] <= conv_cyc_q;
               end
               OFF_STATUS: begin
                  o_prdata[ST_BUSY_BIT] <= o_busy;
                  o_prdata[ST_PD_N_BIT] <= pd_n;
                  o_prdata[ST_SCAN_BIT] <= scan;
                  o_prdata[ST_BYP_BIT] <= byp_q;
                  o_prdata[ST_CHAN_LSB +: SEL_W] <= chan_q;
                  o_prdata[ST_GAIN_LSB +: SEL_W] <= gain_q;
                  o_prdata[ST_CNT_LSB +: 6] <= fifo_cnt;
               end
               OFF_LAST: begin
                  o_prdata[WORD_W-1:0] <= last_q;
               end
               default: begin
                  o_pslverr <= 1'b1;
               end
            endcase
         end
      end
   end
endmodule : acs_ctrl
`default_nettype wire

//--- dv/acs_ctrl_monitor.sv
// Port checker for the converter control block
`default_nettype none
module acs_ctrl_monitor
   import acs_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic o_pready,
   input wire logic i_convert_start_n,
   input wire logic i_powerdown_n,
   input wire logic i_sequencer_enable,
   input wire logic i_chan_sel_msb,
   input wire logic i_chan_sel_mid,
   input wire logic i_chan_sel_lsb,
   input wire logic i_gain_sel_msb_or_amp_bypass,
   input wire logic i_gain_sel_mid,
   input wire logic i_gain_sel_lsb,
   input wire logic o_busy,
   input wire logic o_serial_result_oe_n,
   input wire logic o_core_power_on,
   input wire logic [SEL_W-1:0] o_mux_chan,
   input wire logic [SEL_W-1:0] o_amp_gain
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [15:0] pwr_run_q;
   logic [15:0] busy_run_q;
   logic [5:0] sel;
   assign sel = {i_chan_sel_msb, i_chan_sel_mid, i_chan_sel_lsb,
      i_gain_sel_msb_or_amp_bypass, i_gain_sel_mid, i_gain_sel_lsb};
   default clocking @(posedge i_clk); endclocking
   default disable iff (i_rst);
   // Run lengths of power-on and busy
   always_ff @(posedge i_clk) begin
      pwr_run_q <= (i_rst || !o_core_power_on) ? 16'h0 : pwr_run_q + 16'h1;
   end
   always_ff @(posedge i_clk) begin
      busy_run_q <= (i_rst || !o_busy) ? 16'h0 : busy_run_q + 16'h1;
   end
   sequence s_power_steady;
      i_powerdown_n [*8];
   endsequence
   sequence s_start_fall;
      (!o_busy && i_powerdown_n && i_convert_start_n)
         ##1 (!i_convert_start_n && i_powerdown_n) [*5];
   endsequence
   sequence s_sel_rise;
      (!i_sequencer_enable && !i_convert_start_n)
         ##1 (i_convert_start_n && !i_sequencer_enable && $stable(sel)) [*6];
   endsequence
   AST_OE_OFF: assert property (i_convert_start_n [*4] |=> o_serial_result_oe_n)
      else $error("driver on with start high");
   AST_OE_ON: assert property ((!i_convert_start_n && i_powerdown_n) [*4] |=> !o_serial_result_oe_n)
      else $error("driver off with start low");
   AST_HALT: assert property (!i_powerdown_n [*5] |=> o_serial_result_oe_n && !o_busy)
      else $error("no halt in power-down");
   AST_START: assert property (s_start_fall |-> o_busy)
      else $error("start fall gave no conversion");
   AST_CONV_LEN: assert property (s_power_steady ##0 $fell(o_core_power_on) |-> pwr_run_q == 16'h32)
      else $error("conversion length wrong");
   AST_BUSY_LEN: assert property (s_power_steady ##0 $fell(o_busy) |-> busy_run_q >= 16'h32)
      else $error("busy too short");
   AST_PWR_IN_BUSY: assert property (o_core_power_on |-> o_busy)
      else $error("converter on while not busy");
   AST_SEL_CAP: assert property (s_sel_rise |-> o_mux_chan == sel[5:3] && o_amp_gain == sel[2:0])
      else $error("select capture wrong");
   AST_APB_RDY: assert property (i_psel && !i_penable |=> o_pready)
      else $error("no ready after setup");
endmodule : acs_ctrl_monitor
bind acs_ctrl acs_ctrl_monitor acs_ctrl_monitor_inst (
   .i_clk(i_clk),
   .i_rst(i_rst),
   .i_psel(i_psel),
   .i_penable(i_penable),
   .o_pready(o_pready),
   .i_convert_start_n(i_convert_start_n),
   .i_powerdown_n(i_powerdown_n),
   .i_sequencer_enable(i_sequencer_enable),
   .i_chan_sel_msb(i_chan_sel_msb),
   .i_chan_sel_mid(i_chan_sel_mid),
   .i_chan_sel_lsb(i_chan_sel_lsb),
   .i_gain_sel_msb_or_amp_bypass(i_gain_sel_msb_or_amp_bypass),
   .i_gain_sel_mid(i_gain_sel_mid),
   .i_gain_sel_lsb(i_gain_sel_lsb),
   .o_busy(o_busy),
   .o_serial_result_oe_n(o_serial_result_oe_n),
   .o_core_power_on(o_core_power_on),
   .o_mux_chan(o_mux_chan),
   .o_amp_gain(o_amp_gain)
);
`default_nettype wire

//--- dv/acs_host_model.sv
// Host side model driving start and shift clock
`default_nettype none
module acs_host_model
   import acs_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_sdo,
   output logic o_cs_n,
   output logic o_sck,
   output logic [WORD_W-1:0] o_word,
   output logic o_word_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_cs_n = 1'b0;
      o_sck = 1'b0;
      o_word = '0;
      o_word_valid = 1'b0;
   end
   // Acquisition while start is high, then conversion
   task automatic start();
      @(posedge i_clk);
      o_cs_n <= 1'b1;
      repeat (8) @(posedge i_clk);
      o_cs_n <= 1'b0;
   endtask : start
   // Shift clock of eight cycles, low between words
   task automatic read_word();
      logic [WORD_W-1:0] w;
      w = '0;
      for (int b = 0; b < WORD_W; b++) begin
         @(posedge i_clk);
         o_sck <= 1'b1;
         repeat (5) @(posedge i_clk);
         w = {w[WORD_W-2:0], i_sdo};
         o_sck <= 1'b0;
         repeat (2) @(posedge i_clk);
      end
      o_word <= w;
      o_word_valid <= 1'b1;
      @(posedge i_clk);
      o_word_valid <= 1'b0;
   endtask : read_word
endmodule : acs_host_model
`default_nettype wire

//--- dv/tb_acs_ctrl.sv
// Self-checking bench for the converter control block
`default_nettype none
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin err_total++; \
   $display("CHECK FAILED %0t value mismatch", $time); end end
module tb_acs_ctrl
   import acs_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic i_clk, i_rst, i_psel, i_penable, i_pwrite, o_pready, o_pslverr;
   logic [7:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata, rd;
   logic i_convert_start_n, i_serial_shift_clock, i_sequencer_enable;
   logic i_reduced_power_config, i_powerdown_n, i_gain_sel_msb_float;
   logic i_chan_sel_msb, i_chan_sel_mid, i_chan_sel_lsb;
   logic i_gain_sel_msb_or_amp_bypass, i_gain_sel_mid, i_gain_sel_lsb;
   logic o_busy, o_serial_result_out, o_serial_result_oe_n, e;
   logic [CODE_W-1:0] i_core_code;
   logic o_core_power_on, o_core_acquire, o_amp_bypass, rx_valid;
   logic [SEL_W-1:0] o_mux_chan, o_amp_gain;
   logic [WORD_W-1:0] rx_word;
   logic [WORD_W-1:0] exp_q[$];
   int err_total, n_tests, seed;
   acs_ctrl acs_ctrl_inst (
      .i_clk(i_clk),
      .i_rst(i_rst),
      .i_psel(i_psel),
      .i_penable(i_penable),
      .i_pwrite(i_pwrite),
      .i_paddr(i_paddr),
      .i_pwdata(i_pwdata),
      .o_prdata(o_prdata),
      .o_pready(o_pready),
      .o_pslverr(o_pslverr),
      .i_convert_start_n(i_convert_start_n),
      .i_serial_shift_clock(i_serial_shift_clock),
      .i_sequencer_enable(i_sequencer_enable),
      .i_reduced_power_config(i_reduced_power_config),
      .i_powerdown_n(i_powerdown_n),
      .i_gain_sel_msb_float(i_gain_sel_msb_float),
      .i_chan_sel_msb(i_chan_sel_msb),
      .i_chan_sel_mid(i_chan_sel_mid),
      .i_chan_sel_lsb(i_chan_sel_lsb),
      .i_gain_sel_msb_or_amp_bypass(i_gain_sel_msb_or_amp_bypass),
      .i_gain_sel_mid(i_gain_sel_mid),
      .i_gain_sel_lsb(i_gain_sel_lsb),
      .o_busy(o_busy),
      .o_serial_result_out(o_serial_result_out),
      .o_serial_result_oe_n(o_serial_result_oe_n),
      .i_core_code(i_core_code),
      .o_core_power_on(o_core_power_on),
      .o_core_acquire(o_core_acquire),
      .o_mux_chan(o_mux_chan),
      .o_amp_gain(o_amp_gain),
      .o_amp_bypass(o_amp_bypass)
   );
   // Driver off shows the inverse so a read with the driver off is caught
   acs_host_model acs_host_model_inst (.i_clk(i_clk),
      .i_sdo(o_serial_result_oe_n ? ~o_serial_result_out : o_serial_result_out),
      .o_cs_n(i_convert_start_n), .o_sck(i_serial_shift_clock),
      .o_word(rx_word), .o_word_valid(rx_valid));
   initial begin
      i_clk = 1'b0;
      forever #10 i_clk = ~i_clk;
   end
   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", n_tests, err_total);
      if (err_total == 0 && n_tests > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : print_verdict
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= a;
      i_pwdata <= d;
      @(posedge i_clk);
      i_penable <= 1'b1;
      do begin
         @(posedge i_clk);
      end while (!o_pready);
      rd = o_prdata;
      e = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask : apb
   // One conversion; halt drops power-down once busy
   task automatic conv(input int k, input bit halt);
      logic [2:0] c, g;
      logic [CODE_W-1:0] x;
      int n;
      c = 3'($urandom);
      g = 3'($urandom);
      if (i_gain_sel_msb_float) g[2] = i_gain_sel_msb_or_amp_bypass;
      x = CODE_W'($urandom);
      n = 0;
      @(posedge i_clk);
      {i_chan_sel_msb, i_chan_sel_mid, i_chan_sel_lsb} <= c;
      {i_gain_sel_msb_or_amp_bypass, i_gain_sel_mid, i_gain_sel_lsb} <= g;
      i_core_code <= x;
      acs_host_model_inst.start();
      @(posedge i_clk);
      `CHK(o_core_acquire, 1'b1)
      {i_chan_sel_msb, i_chan_sel_mid, i_chan_sel_lsb} <= ~c;
      {i_gain_sel_msb_or_amp_bypass, i_gain_sel_mid, i_gain_sel_lsb} <=
         ~g ^ {i_gain_sel_msb_float, 2'b00};
      while (!o_busy && n < 20) begin
         @(posedge i_clk);
         n++;
      end
      `CHK({o_busy, o_core_acquire}, 2'b10)
      if (halt) begin
         i_powerdown_n <= 1'b0;
      end else begin
         while (o_busy && n < 400) begin
            @(posedge i_clk);
            n++;
         end
         `CHK(o_busy, 1'b0)
         exp_q.push_back({x, i_sequencer_enable ? 3'(k) : c, g});
      end
   endtask : conv
   always @(posedge i_clk) begin
      if (rx_valid) begin
         `CHK(rx_word, exp_q.pop_front())
      end
   end
   initial begin
      repeat (40000) @(posedge i_clk);
      err_total++;
      print_verdict();
   end
   initial begin
      seed = $urandom(32'h8c8e);
      {i_rst, i_psel, i_penable, i_pwrite, i_paddr, i_pwdata} = {2'h2, 42'h0};
      {i_sequencer_enable, i_gain_sel_msb_float, i_core_code} = '0;
      {i_chan_sel_msb, i_chan_sel_mid, i_chan_sel_lsb} = 3'h0;
      {i_gain_sel_msb_or_amp_bypass, i_gain_sel_mid, i_gain_sel_lsb} = 3'h0;
      i_reduced_power_config = 1'b1;
      i_powerdown_n = 1'b1;
      repeat (16) @(posedge i_clk);
      i_rst <= 1'b0;
      repeat (4) @(posedge i_clk);
      apb(1'b0, OFF_CTRL, 32'h0);
      `CHK(rd[CTRL_EN_BIT], CTRL_EN_RST)
      apb(1'b0, OFF_CONV, 32'h0);
      `CHK(rd[15:0], CONV_RST)
      apb(1'b1, OFF_CONV, 32'h32);
      apb(1'b0, 8'h10, 32'h0);
      `CHK({e, rd}, {1'b1, 32'h0})
      for (int k = 0; k < 3; k++) begin
         conv(k, 1'b0);
         acs_host_model_inst.read_word();
      end
      @(posedge i_clk);
      i_sequencer_enable <= 1'b1;
      for (int k = 0; k < 33; k++) conv(k, 1'b0);
      apb(1'b0, OFF_STATUS, 32'h0);
      `CHK({rd[21:16], rd[3:0], o_amp_bypass}, {6'h20, 4'h6, 1'b0})
      repeat (33) acs_host_model_inst.read_word();
      i_sequencer_enable <= 1'b0;
      conv(0, 1'b1);
      repeat (8) @(posedge i_clk);
      `CHK({o_busy, o_serial_result_oe_n}, 2'h1)
      i_powerdown_n <= 1'b1;
      i_gain_sel_msb_float <= 1'b1;
      repeat (4) @(posedge i_clk);
      conv(0, 1'b0);
      `CHK(o_amp_bypass, 1'b1)
      apb(1'b0, OFF_LAST, 32'h0);
      `CHK(rd[WORD_W-1:0], exp_q[0])
      acs_host_model_inst.read_word();
      repeat (4) @(posedge i_clk);
      print_verdict();
   end
endmodule : tb_acs_ctrl
`default_nettype wire
